// [core/fepcs_params.svh]
// Constants for the 100 Mb/s line coding block: register map, field
// positions, reset values, code groups and bit counts.
// Assumes inclusion by bare name from the design, checker and bench files.
`ifndef FEPCS_PARAMS_SVH
`define FEPCS_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define FEPCS_REG_CTRL      5'h10
`define FEPCS_REG_STAT      5'h11
`define FEPCS_CTRL_FDX      0
`define FEPCS_CTRL_SYM      1
`define FEPCS_CTRL_TXINV    2
`define FEPCS_CTRL_SPD10    3
`define FEPCS_CTRL_ANEG     4
`define FEPCS_STAT_LOCK     4
`define FEPCS_STAT_PREM     5
`define FEPCS_STAT_HALT     6
`define FEPCS_STAT_INV      7
`define FEPCS_STAT_POLR     8
`define FEPCS_CTRL_RST      5'h00

// ----------------------------------------------------------------
// Code groups, first bit on the line in bit 4
// ----------------------------------------------------------------
`define FEPCS_DATA_CG       80'hef37a_bda72_7b96a_ad13e
`define FEPCS_CG_I          5'h1f
`define FEPCS_CG_J          5'h18
`define FEPCS_CG_K          5'h11
`define FEPCS_CG_T          5'h0d
`define FEPCS_CG_R          5'h07
`define FEPCS_CG_H          5'h04
`define FEPCS_CG_BAD        5'h00
`define FEPCS_PREAMBLE      4'h5

// ----------------------------------------------------------------
// Scrambler and receive counts
// ----------------------------------------------------------------
`define FEPCS_SEED_HI       6'h2a
`define FEPCS_LOCK_BITS     5'h1e
`define FEPCS_CD_LAST       4'h9
`define FEPCS_SYM_LAST      4'h4

`endif

// [core/fepcs_pkg.sv]
// Types shared by the line coding block.
// Assumes fepcs_params.svh on the include path.
package fepcs_pkg;

    typedef enum logic [1:0] {
        rx_idle,
        rx_carrier,
        rx_recv
    } fepcs_rx_state_e;

    typedef enum logic [1:0] {
        tx_idle,
        tx_ssd_k,
        tx_data,
        tx_esd_r
    } fepcs_tx_state_e;

    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] d;
    } fepcs_mii_tx_s;

    typedef struct packed {
        logic aneg;
        logic spd10;
        logic tx_inv;
        logic sym;
        logic fdx;
    } fepcs_ctrl_s;

endpackage

// [core/fepcs_top.sv]
// Line coding path of a twisted-pair PHY at 100 Mb/s: 4B/5B coding,
// scrambling, MLT-3, carrier sense, collision and status registers.
// Assumes i_clk is the 25 MHz reference that also clocks the nibble
// side; the recovered receive clock and line levels come from outside.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "fepcs_params.svh"

module fepcs_top
    import fepcs_pkg::*;
(
    input  wire logic          i_clk,
    input  wire logic          i_resetn,
    input  wire logic [4:0]    i_addr,
    input  wire logic [15:0]   i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic      [15:0]   o_rdata,
    input  wire logic [4:0]    i_phy_addr,
    input  wire fepcs_mii_tx_s i_mii_tx,
    input  wire logic [4:0]    i_tx_sym,
    input  wire logic          i_man_tx,
    input  wire logic          i_rx_link_clk,
    input  wire logic          i_line_rx_pos,
    input  wire logic          i_line_rx_neg,
    output logic      [4:0]    o_line_tx_pos,
    output logic      [4:0]    o_line_tx_neg,
    output logic      [3:0]    o_rxd,
    output logic               o_rx_dv,
    output logic               o_rx_er,
    output logic               o_rx_stb,
    output logic               o_crs,
    output logic               o_col
);

    // ----------------------------------------------------------------
    // Code group helpers
    // ----------------------------------------------------------------
    localparam logic [79:0] DATA_CG = `FEPCS_DATA_CG;

    function automatic logic [4:0] fepcs_enc(input logic [3:0] n);
        fepcs_enc = DATA_CG[{n, 2'b00} + {3'b000, n} +: 5];
    endfunction

    // Returns {hit, nibble}
    function automatic logic [4:0] fepcs_dec(input logic [4:0] s);
        fepcs_dec = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (DATA_CG[i*5 +: 5] == s) begin
                fepcs_dec = {1'b1, 4'(i)};
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    fepcs_ctrl_s ctrl_r;
    fepcs_ctrl_s ctrl_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        inv_r;
    logic        inv_nxt;
    logic        halt_r;
    logic        halt_nxt;
    logic        prem_r;
    logic        prem_nxt;
    logic        stat_clr;
    logic        set_inv;
    logic        set_halt;
    logic        set_prem;
    logic        pol_r;
    logic [4:0]  lock_r;
    logic        locked;

    assign locked   = (lock_r == `FEPCS_LOCK_BITS);
    assign stat_clr = i_rd && (i_addr == `FEPCS_REG_STAT);

    always_comb begin
        ctrl_nxt  = ctrl_r;
        rdata_nxt = rdata_r;
        if (i_wr && (i_addr == `FEPCS_REG_CTRL)) begin
            ctrl_nxt.fdx    = i_wdata[`FEPCS_CTRL_FDX];
            ctrl_nxt.sym    = i_wdata[`FEPCS_CTRL_SYM];
            ctrl_nxt.tx_inv = i_wdata[`FEPCS_CTRL_TXINV];
            ctrl_nxt.spd10  = i_wdata[`FEPCS_CTRL_SPD10];
            ctrl_nxt.aneg   = i_wdata[`FEPCS_CTRL_ANEG];
        end
        if (i_rd) begin
            rdata_nxt = 16'h0000;
            if (i_addr == `FEPCS_REG_CTRL) begin
                rdata_nxt[`FEPCS_CTRL_FDX]   = ctrl_r.fdx;
                rdata_nxt[`FEPCS_CTRL_SYM]   = ctrl_r.sym;
                rdata_nxt[`FEPCS_CTRL_TXINV] = ctrl_r.tx_inv;
                rdata_nxt[`FEPCS_CTRL_SPD10] = ctrl_r.spd10;
                rdata_nxt[`FEPCS_CTRL_ANEG]  = ctrl_r.aneg;
            end else if (i_addr == `FEPCS_REG_STAT) begin
                rdata_nxt[`FEPCS_STAT_LOCK] = locked;
                rdata_nxt[`FEPCS_STAT_PREM] = prem_r;
                rdata_nxt[`FEPCS_STAT_HALT] = halt_r;
                rdata_nxt[`FEPCS_STAT_INV]  = inv_r;
                rdata_nxt[`FEPCS_STAT_POLR] = pol_r;
            end
        end
        // Latching flags: a new event wins over the read that clears
        inv_nxt  = set_inv  | (inv_r  & ~stat_clr);
        halt_nxt = set_halt | (halt_r & ~stat_clr);
        prem_nxt = set_prem | (prem_r & ~stat_clr);
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_r  <= `FEPCS_CTRL_RST;
            rdata_r <= 16'h0000;
            inv_r   <= 1'b0;
            halt_r  <= 1'b0;
            prem_r  <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            inv_r   <= inv_nxt;
            halt_r  <= halt_nxt;
            prem_r  <= prem_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // ----------------------------------------------------------------
    // Transmit: framing, 4B/5B, scrambler, MLT-3
    // ----------------------------------------------------------------
    fepcs_tx_state_e tx_st_r;
    fepcs_tx_state_e tx_st_nxt;
    logic [10:0]     tx_lfsr_r;
    logic [10:0]     tx_lfsr_nxt;
    logic            seeded_r;
    logic            seeded_nxt;
    logic [1:0]      phase_r;
    logic [1:0]      phase_nxt;
    logic [4:0]      txp_r;
    logic [4:0]      txp_nxt;
    logic [4:0]      txn_r;
    logic [4:0]      txn_nxt;
    logic [4:0]      tx_cg;
    logic            tx_bit;
    logic            tx_key;

    always_comb begin
        tx_st_nxt   = tx_st_r;
        tx_cg       = `FEPCS_CG_I;
        tx_bit      = 1'b0;
        tx_key      = 1'b0;
        seeded_nxt  = 1'b1;
        tx_lfsr_nxt = tx_lfsr_r;
        phase_nxt   = phase_r;
        txp_nxt     = 5'h00;
        txn_nxt     = 5'h00;
        unique case (tx_st_r)
            tx_idle: begin
                if (i_mii_tx.en) begin
                    tx_cg     = `FEPCS_CG_J;
                    tx_st_nxt = tx_ssd_k;
                end
            end
            tx_ssd_k: begin
                tx_cg     = `FEPCS_CG_K;
                tx_st_nxt = tx_data;
            end
            tx_data: begin
                if (!i_mii_tx.en) begin
                    tx_cg     = `FEPCS_CG_T;
                    tx_st_nxt = tx_esd_r;
                end else if (i_mii_tx.er) begin
                    tx_cg = ctrl_r.tx_inv ? `FEPCS_CG_BAD : `FEPCS_CG_H;
                end else begin
                    tx_cg = fepcs_enc(i_mii_tx.d);
                end
            end
            tx_esd_r: begin
                tx_cg     = `FEPCS_CG_R;
                tx_st_nxt = tx_idle;
            end
        endcase
        if (ctrl_r.sym) begin
            tx_cg = i_tx_sym;
        end
        if (!seeded_r) begin
            tx_lfsr_nxt = {`FEPCS_SEED_HI, i_phy_addr};
        end
        for (int b = 4; b >= 0; b--) begin
            tx_key      = tx_lfsr_nxt[10] ^ tx_lfsr_nxt[8];
            tx_lfsr_nxt = {tx_lfsr_nxt[9:0], tx_key};
            tx_bit      = ctrl_r.sym ? tx_cg[b] : (tx_cg[b] ^ tx_key);
            // A one steps the level through 0, +1, 0, -1
            phase_nxt   = phase_nxt + {1'b0, tx_bit};
            txp_nxt[b]  = (phase_nxt == 2'b01);
            txn_nxt[b]  = (phase_nxt == 2'b11);
        end
        if (ctrl_r.spd10) begin
            txp_nxt = {5{i_man_tx}};
            txn_nxt = {5{~i_man_tx}};
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_st_r   <= tx_idle;
            tx_lfsr_r <= 11'h7ff;
            seeded_r  <= 1'b0;
            phase_r   <= 2'b00;
            txp_r     <= 5'h00;
            txn_r     <= 5'h00;
        end else begin
            tx_st_r   <= tx_st_nxt;
            tx_lfsr_r <= tx_lfsr_nxt;
            seeded_r  <= seeded_nxt;
            phase_r   <= phase_nxt;
            txp_r     <= txp_nxt;
            txn_r     <= txn_nxt;
        end
    end

    assign o_line_tx_pos = txp_r;
    assign o_line_tx_neg = txn_r;

    // ----------------------------------------------------------------
    // Receive line sampling: three stages, edge of recovered clock
    // ----------------------------------------------------------------
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic       clk_lvl_r;
    logic       clk_lvl_nxt;
    logic       rx_edge;

    assign rx_edge     = sync2_r[2] & sync3_r[2] & ~clk_lvl_r;
    assign clk_lvl_nxt = (sync2_r[2] == sync3_r[2]) ? sync3_r[2] : clk_lvl_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_r   <= 3'h0;
            sync2_r   <= 3'h0;
            sync3_r   <= 3'h0;
            clk_lvl_r <= 1'b0;
        end else begin
            sync1_r   <= {i_rx_link_clk, i_line_rx_pos, i_line_rx_neg};
            sync2_r   <= sync1_r;
            sync3_r   <= sync2_r;
            clk_lvl_r <= clk_lvl_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Receive: polarity, MLT-3, descrambler, framing and decode
    // ----------------------------------------------------------------
    fepcs_rx_state_e rx_st_r;
    fepcs_rx_state_e rx_st_nxt;
    logic [1:0]      raw_prev_r;
    logic [1:0]      lvl_prev_r;
    logic [1:0]      lvl_prev_nxt;
    logic            pol_nxt;
    logic [10:0]     key_r;
    logic [10:0]     key_nxt;
    logic [4:0]      lock_nxt;
    logic [9:0]      win_r;
    logic [9:0]      win_nxt;
    logic            zero_r;
    logic            zero_nxt;
    logic            gap_r;
    logic            gap_nxt;
    logic [3:0]      cnt_r;
    logic [3:0]      cnt_nxt;
    logic            tseen_r;
    logic            tseen_nxt;
    logic            pend_r;
    logic            pend_nxt;
    logic [3:0]      rxd_r;
    logic [3:0]      rxd_nxt;
    logic            er_r;
    logic            er_nxt;
    logic            stb_r;
    logic            stb_nxt;
    logic [1:0]      raw;
    logic [1:0]      lvl;
    logic            sbit;
    logic            kp;
    logic            pb;
    logic [4:0]      dec;

    assign raw = sync3_r[1:0];

    always_comb begin
        rx_st_nxt    = rx_st_r;
        lvl_prev_nxt = lvl_prev_r;
        pol_nxt      = pol_r;
        key_nxt      = key_r;
        lock_nxt     = lock_r;
        win_nxt      = win_r;
        zero_nxt     = zero_r;
        gap_nxt      = gap_r;
        cnt_nxt      = cnt_r;
        tseen_nxt    = tseen_r;
        pend_nxt     = 1'b0;
        rxd_nxt      = rxd_r;
        er_nxt       = er_r;
        stb_nxt      = 1'b0;
        set_inv      = 1'b0;
        set_halt     = 1'b0;
        set_prem     = 1'b0;
        lvl          = pol_r ? {raw[0], raw[1]} : raw;
        sbit         = (lvl != lvl_prev_r);
        kp           = key_r[10] ^ key_r[8];
        pb           = 1'b1;
        dec          = fepcs_dec(win_r[3:0] == 4'h0 ? 5'h00 : {win_r[3:0], pb});
        if (pend_r) begin
            stb_nxt = 1'b1;
            rxd_nxt = `FEPCS_PREAMBLE;
            er_nxt  = 1'b0;
        end
        if (rx_edge) begin
            // Positive link pulses: a pulse that starts negative means swapped pair
            if ((ctrl_r.spd10 || ctrl_r.aneg) && raw_prev_r == 2'b00 && ^raw) begin
                pol_nxt = raw[0];
            end
            lvl_prev_nxt = lvl;
            if (ctrl_r.sym) begin
                pb = sbit;
            end else if (locked) begin
                pb      = sbit ^ kp;
                key_nxt = {key_r[9:0], kp};
            end else begin
                // Idle carries all ones, so the keystream is the inverted line
                key_nxt  = {key_r[9:0], ~sbit};
                lock_nxt = (kp == ~sbit) ? lock_r + 5'h01 : 5'h00;
            end
            win_nxt = {win_r[8:0], pb};
            dec     = fepcs_dec(win_nxt[4:0]);
            unique case (rx_st_r)
                rx_idle: begin
                    if (!zero_r) begin
                        if (!pb) begin
                            zero_nxt = 1'b1;
                            gap_nxt  = 1'b0;
                            cnt_nxt  = 4'h0;
                        end
                    end else begin
                        cnt_nxt = cnt_r + 4'h1;
                        if (pb) begin
                            gap_nxt = 1'b1;
                        end
                        if (!pb && gap_r) begin
                            rx_st_nxt = rx_carrier;
                            zero_nxt  = 1'b0;
                            cnt_nxt   = 4'h0;
                        end else if (cnt_r == `FEPCS_CD_LAST) begin
                            zero_nxt = 1'b0;
                        end
                    end
                end
                rx_carrier: begin
                    cnt_nxt = cnt_r + 4'h1;
                    if (win_nxt == {`FEPCS_CG_J, `FEPCS_CG_K}) begin
                        rx_st_nxt = rx_recv;
                        cnt_nxt   = 4'h0;
                        tseen_nxt = 1'b0;
                        stb_nxt   = 1'b1;
                        rxd_nxt   = `FEPCS_PREAMBLE;
                        er_nxt    = 1'b0;
                        pend_nxt  = 1'b1;
                    end else if (cnt_r == `FEPCS_CD_LAST && win_nxt != {`FEPCS_CG_I, `FEPCS_CG_J}) begin
                        rx_st_nxt = rx_idle;
                        stb_nxt   = 1'b1;
                        er_nxt    = 1'b1;
                    end
                end
                rx_recv: begin
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == `FEPCS_SYM_LAST) begin
                        cnt_nxt = 4'h0;
                        er_nxt  = 1'b0;
                        if (tseen_r) begin
                            tseen_nxt = 1'b0;
                            rx_st_nxt = rx_idle;
                            if (win_nxt[4:0] != `FEPCS_CG_R) begin
                                stb_nxt = 1'b1;
                                er_nxt  = 1'b1;
                            end
                        end else if (dec[4]) begin
                            stb_nxt = 1'b1;
                            rxd_nxt = dec[3:0];
                        end else if (win_nxt[4:0] == `FEPCS_CG_T) begin
                            tseen_nxt = 1'b1;
                        end else begin
                            stb_nxt = 1'b1;
                            er_nxt  = 1'b1;
                            if (win_nxt[4:0] == `FEPCS_CG_I) begin
                                set_prem  = 1'b1;
                                rx_st_nxt = rx_idle;
                            end else if (win_nxt[4:0] == `FEPCS_CG_H) begin
                                set_halt = 1'b1;
                            end else if (win_nxt[4:0] != `FEPCS_CG_J && win_nxt[4:0] != `FEPCS_CG_K
                                         && win_nxt[4:0] != `FEPCS_CG_R) begin
                                set_inv = 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    rx_st_nxt = rx_idle;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_st_r    <= rx_idle;
            raw_prev_r <= 2'b00;
            lvl_prev_r <= 2'b00;
            pol_r      <= 1'b0;
            key_r      <= 11'h000;
            lock_r     <= 5'h00;
            win_r      <= 10'h3ff;
            zero_r     <= 1'b0;
            gap_r      <= 1'b0;
            cnt_r      <= 4'h0;
            tseen_r    <= 1'b0;
            pend_r     <= 1'b0;
            rxd_r      <= 4'h0;
            er_r       <= 1'b0;
            stb_r      <= 1'b0;
        end else begin
            rx_st_r    <= rx_st_nxt;
            raw_prev_r <= rx_edge ? raw : raw_prev_r;
            lvl_prev_r <= lvl_prev_nxt;
            pol_r      <= pol_nxt;
            key_r      <= key_nxt;
            lock_r     <= lock_nxt;
            win_r      <= win_nxt;
            zero_r     <= zero_nxt;
            gap_r      <= gap_nxt;
            cnt_r      <= cnt_nxt;
            tseen_r    <= tseen_nxt;
            pend_r     <= pend_nxt;
            rxd_r      <= rxd_nxt;
            er_r       <= er_nxt;
            stb_r      <= stb_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Nibble side outputs, carrier sense and collision
    // ----------------------------------------------------------------
    logic receiving;
    logic tx_active;

    assign receiving = (rx_st_r != rx_idle);
    assign tx_active = (tx_st_r != tx_idle);
    assign o_rxd     = rxd_r;
    assign o_rx_er   = er_r;
    assign o_rx_stb  = stb_r;
    assign o_rx_dv   = (rx_st_r == rx_recv);
    assign o_crs     = receiving | (tx_active & ~ctrl_r.fdx);
    assign o_col     = receiving & tx_active & ~ctrl_r.fdx;

endmodule

// [dv/fepcs_chk.sv]
// Checker for the line coding block, bound to its top module.
// Assumes only the top ports; control bits are shadowed from bus writes.
`timescale 1ns/1ps
`include "fepcs_params.svh"
module fepcs_chk
    import fepcs_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic [4:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [4:0]  i_tx_sym,
    input wire logic [4:0]  o_line_tx_pos,
    input wire logic [4:0]  o_line_tx_neg,
    input wire logic        o_rx_dv,
    input wire logic        o_crs,
    input wire logic        o_col
);
    logic [4:0] ctl_r;
    logic [4:0] ctl_nxt;
    logic [1:0] lst_r;
    logic [4:0] chg;
    logic       jmp;
    always_comb begin
        ctl_nxt = ctl_r;
        if (i_wr && i_addr == `FEPCS_REG_CTRL) begin
            ctl_nxt = i_wdata[4:0];
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctl_r <= 5'h00;
            lst_r <= 2'h0;
        end else begin
            ctl_r <= ctl_nxt;
            lst_r <= {o_line_tx_pos[0], o_line_tx_neg[0]};
        end
    end
    // Level change ahead of each line bit, first bit in bit 4
    assign chg = {(o_line_tx_pos[4] != lst_r[1]) || (o_line_tx_neg[4] != lst_r[0]),
                  (o_line_tx_pos[3:0] ^ o_line_tx_pos[4:1]) | (o_line_tx_neg[3:0] ^ o_line_tx_neg[4:1])};
    assign jmp = (|((o_line_tx_pos[4:1] & o_line_tx_neg[3:0]) | (o_line_tx_neg[4:1] & o_line_tx_pos[3:0])))
                 || (o_line_tx_pos[4] && lst_r[0]) || (o_line_tx_neg[4] && lst_r[1]);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    chk_rd_unmapped: assert property (i_rd && i_addr != `FEPCS_REG_CTRL && i_addr != `FEPCS_REG_STAT
        |=> o_rdata == 16'h0000) else $error("unmapped read not zero");
    chk_ctrl_readback: assert property (i_rd && i_addr == `FEPCS_REG_CTRL |=> o_rdata == {11'h000, $past(ctl_r)})
        else $error("control readback differs");
    chk_rdata_hold: assert property (!i_rd |=> $stable(o_rdata)) else $error("read data moved without read");
    chk_line_levels: assert property ((o_line_tx_pos & o_line_tx_neg) == 5'h00)
        else $error("line driven both ways");
    chk_mlt3_steps: assert property (!ctl_r[`FEPCS_CTRL_SPD10] && !$past(ctl_r[`FEPCS_CTRL_SPD10]) |-> !jmp)
        else $error("line level skipped zero");
    chk_sym_bypass: assert property (ctl_r[`FEPCS_CTRL_SYM] && $past(ctl_r[`FEPCS_CTRL_SYM], 2)
        && !ctl_r[`FEPCS_CTRL_SPD10] && !$past(ctl_r[`FEPCS_CTRL_SPD10], 2) |=> chg == $past(i_tx_sym))
        else $error("symbol not sent unscrambled");
    chk_dv_crs: assert property (o_rx_dv |-> o_crs) else $error("receive without carrier");
    chk_col_half: assert property (o_col |-> o_crs && !ctl_r[`FEPCS_CTRL_FDX])
        else $error("collision in full duplex or without carrier");
endmodule

// [dv/fepcs_line_model.sv]
// Cable-side sender: code groups as MLT-3 levels on a 320 ns bit clock.
// Assumes the bench queues groups; idle ones fill every empty bit.
`timescale 1ns/1ps
module fepcs_line_model (
    output logic o_link_clk,
    output logic o_pos,
    output logic o_neg
);
    logic       bit_q [$];
    logic [1:0] ph_r;
    logic       b;
    task automatic push_grp(input logic [4:0] g);
        for (int i = 4; i >= 0; i--) bit_q.push_back(g[i]);
    endtask
    initial begin
        o_link_clk = 1'b0;
        ph_r = 2'h0;
        o_pos = 1'b0;
        o_neg = 1'b0;
        #7;
        forever begin
            b = (bit_q.size() != 0) ? bit_q.pop_front() : 1'b1;
            if (b) ph_r = ph_r + 2'h1;
            o_pos = (ph_r == 2'h1);
            o_neg = (ph_r == 2'h3);
            #160 o_link_clk = 1'b1;
            #160 o_link_clk = 1'b0;
        end
    end
endmodule

// [dv/tb_top.sv]
// Bench for the line coding block: bus tasks, symbol transmit, received frames.
// Assumes the cable model sends idle ones whenever nothing is queued.
`timescale 1ns/1ps
`include "fepcs_params.svh"
module tb_top
    import fepcs_pkg::*;
;
    logic          i_clk, i_resetn, i_wr, i_rd, lclk, rx_pos, rx_neg, man;
    logic [4:0]    i_addr, i_tx_sym, tx_pos, tx_neg;
    logic [15:0]   i_wdata, o_rdata;
    fepcs_mii_tx_s i_mii_tx;
    logic [3:0]    o_rxd;
    logic          o_rx_dv, o_rx_er, o_rx_stb, o_crs, o_col, dv_seen, crs_seen, col_seen;
    logic [4:0]    got_q [$];
    int            miscompares, cmp_count;
    always #20 i_clk = ~i_clk;
    fepcs_top u_fepcs_top (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_phy_addr(5'h03), .i_mii_tx(i_mii_tx), .i_tx_sym(i_tx_sym), .i_man_tx(man),
        .i_rx_link_clk(lclk), .i_line_rx_pos(rx_pos), .i_line_rx_neg(rx_neg), .o_line_tx_pos(tx_pos),
        .o_line_tx_neg(tx_neg), .o_rxd(o_rxd), .o_rx_dv(o_rx_dv), .o_rx_er(o_rx_er), .o_rx_stb(o_rx_stb),
        .o_crs(o_crs), .o_col(o_col));
    fepcs_line_model u_fepcs_line_model (.o_link_clk(lclk), .o_pos(rx_pos), .o_neg(rx_neg));
    always @(posedge i_clk) begin
        if (o_rx_stb === 1'b1) got_q.push_back({o_rx_er, o_rxd});
        if (o_rx_dv === 1'b1) dv_seen = 1'b1;
        if (o_crs === 1'b1) crs_seen = 1'b1;
        if (o_col === 1'b1) col_seen = 1'b1;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic chk_reg(input string nm, input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 cmp(nm, e, o_rdata & m);
    endtask
    task automatic send(input logic [4:0] g [$], input logic [4:0] e [$]);
        int n;
        got_q.delete();
        foreach (g[i]) u_fepcs_line_model.push_grp(g[i]);
        repeat (3) u_fepcs_line_model.push_grp(`FEPCS_CG_I);
        for (n = 0; n < 20000 && u_fepcs_line_model.bit_q.size() != 0; n++)
            @(posedge i_clk);
        if (n == 20000) begin
            miscompares++;
            end_sim();
        end
        cmp("rx count", 16'(e.size()), 16'(got_q.size()));
        foreach (e[i]) if (i < got_q.size()) cmp("rx group", 16'(e[i]), 16'(got_q[i] & (e[i][4] ? 5'h10 : 5'h1f)));
    endtask
    initial begin
        {i_clk, i_resetn, i_wr, i_rd, dv_seen, crs_seen, col_seen, man, i_addr, i_wdata, i_mii_tx} = 35'h0;
        i_tx_sym = `FEPCS_CG_I;
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        chk_reg("ctrl reset", `FEPCS_REG_CTRL, 16'hffff, 16'h0000);
        chk_reg("status reset", `FEPCS_REG_STAT, 16'h00e0, 16'h0000);
        chk_reg("unmapped", 5'h05, 16'hffff, 16'h0000);
        wr(`FEPCS_REG_STAT, 16'hffff);
        chk_reg("status write", `FEPCS_REG_STAT, 16'h00e0, 16'h0000);
        wr(`FEPCS_REG_CTRL, 16'h0002);
        chk_reg("ctrl", `FEPCS_REG_CTRL, 16'hffff, 16'h0002);
        $display("test registers done");
        for (int k = 0; k < 32; k++) begin
            @(posedge i_clk);
            i_tx_sym <= 5'(k);
        end
        $display("test symbol transmit done");
        i_mii_tx <= '{en: 1'b1, er: 1'b0, d: 4'h5};
        send('{5'h18, 5'h11, 5'h1e, 5'h09, 5'h16, 5'h1d, 5'h0d, 5'h07}, '{5'h05, 5'h05, 5'h00, 5'h01, 5'h0a, 5'h0f});
        i_mii_tx <= '0;
        cmp("dv seen", 16'h0001, 16'(dv_seen));
        cmp("col seen", 16'h0001, 16'(col_seen));
        $display("test frame done");
        send('{5'h18, 5'h11, 5'h04, 5'h01, 5'h0d, 5'h07}, '{5'h05, 5'h05, 5'h10, 5'h10});
        chk_reg("status flags", `FEPCS_REG_STAT, 16'h00c0, 16'h00c0);
        chk_reg("status clear", `FEPCS_REG_STAT, 16'h00c0, 16'h0000);
        $display("test code errors done");
        crs_seen = 1'b0;
        send('{5'h15}, '{5'h10});
        cmp("carrier seen", 16'h0001, 16'(crs_seen));
        cmp("carrier dropped", 16'h0000, 16'(o_crs));
        $display("test false carrier done");
        wr(`FEPCS_REG_CTRL, 16'h0003);
        i_mii_tx <= '{en: 1'b1, er: 1'b0, d: 4'h5};
        col_seen = 1'b0;
        send('{5'h18, 5'h11, 5'h1e, 5'h0d, 5'h07}, '{5'h05, 5'h05, 5'h00});
        i_mii_tx <= '0;
        cmp("full duplex col", 16'h0000, 16'(col_seen));
        $display("test full duplex done");
        wr(`FEPCS_REG_CTRL, 16'h0009);
        man <= 1'b1;
        repeat (2) @(posedge i_clk);
        cmp("manchester", 16'h03e0, 16'({tx_pos, tx_neg}));
        $display("test manchester done");
        end_sim();
    end
endmodule
bind fepcs_top fepcs_chk u_fepcs_chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_tx_sym(i_tx_sym), .o_line_tx_pos(o_line_tx_pos), .o_line_tx_neg(o_line_tx_neg),
    .o_rx_dv(o_rx_dv), .o_crs(o_crs), .o_col(o_col));
